// ===== rtl/hsfo_ctrl.sv
// Digital control of a two-channel hot-swap and ORing controller.
// Assumes a serial front end that delivers decoded register accesses
// on the clk domain, and analog comparators arriving asynchronously.
`timescale 1ns/10ps
`include "hsfo_params.svh"

module hsfo_ctrl
   import hsfo_pkg::*;
#(
   parameter int STEP_CYCLES = `HSFO_STEP_NS / `HSFO_CLK_NS
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Decoded register accesses
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // Comparators and channel enable pins
   input  wire hsfo_cmp_t   cmp_in,
   // Switch drives
   output logic             blocking_gate_drive,
   output logic      [1:0]  pass_gate_on,
   output logic      [1:0]  bleed_switch_on
);

   // Index 0 is the 12-V channel, index 1 the 3.3-V channel
   localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

   hsfo_cmp_t   s1_q;
   hsfo_cmp_t   s2_q;
   hsfo_cmp_t   s3_q;
   hsfo_cmp_t   cmp_q;
   hsfo_ctrl_t  ctrl_q;
   logic [4:0]  ft_q [2];
   logic [1:0]  flt_q;
   logic        blk_q;
   logic [1:0]  pass_q;
   logic [1:0]  bleed_q;
   logic [7:0]  rdata_q;
   hsfo_state_t st_q [2];
   logic [15:0] cyc_q [2];
   logic [11:0] stp_q [2];

   logic [1:0]  en;
   logic [1:0]  cl;
   logic [1:0]  rail_low;
   logic [1:0]  ds_en;
   logic [1:0]  bleed_en;
   logic [1:0]  wrap;
   logic [1:0]  trip;
   logic [1:0]  retry_done;
   logic        wr_status;

   // Step count at which the timer ends; mult is 1 or the retry factor
   function automatic logic [11:0] step_target(
      input logic [4:0] code,
      input logic       retry
   );
      logic [11:0] mult;
      mult = retry ? 12'(`HSFO_RETRY_MULT) : 12'h0001;
      step_target = 12'(code * mult);
   endfunction : step_target

   // True when the last step of a timer completes this cycle
   function automatic logic step_hit(
      input logic [11:0] stp,
      input logic [11:0] target,
      input logic        wrp
   );
      step_hit = wrp && (target != 12'h000) && (12'(stp + 12'h001) == target);
   endfunction : step_hit

   // Register read decode; unmapped numbers read as zero
   function automatic logic [7:0] reg_read(input logic [7:0] addr);
      logic [7:0] st;
      st = 8'h00;
      st[`HSFO_ST_FLT_HV]   = flt_q[0];
      st[`HSFO_ST_FLT_LV]   = flt_q[1];
      st[`HSFO_ST_BLK]      = blk_q;
      st[`HSFO_ST_PASS_HV]  = pass_q[0];
      st[`HSFO_ST_PASS_LV]  = pass_q[1];
      st[`HSFO_ST_BLEED_HV] = bleed_q[0];
      st[`HSFO_ST_BLEED_LV] = bleed_q[1];
      unique case (addr)
         `HSFO_REG_FT_HV:  reg_read = {3'h0, ft_q[0]};
         `HSFO_REG_FT_LV:  reg_read = {3'h0, ft_q[1]};
         `HSFO_REG_CTRL:   reg_read = ctrl_q;
         `HSFO_REG_STATUS: reg_read = st;
         default:          reg_read = 8'h00;
      endcase
   endfunction : reg_read

   // Three-stage pin synchroniser; a level counts once stages two
   // and three agree, which rejects a single-cycle glitch
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         cmp_q <= '0;
      end
      else
      begin
         s1_q  <= cmp_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         cmp_q <= hsfo_cmp_t'((s2_q & s3_q) | (cmp_q & (s2_q | s3_q)));
      end
   end

   // Per-channel views of the filtered pins and control bits
   assign en        = {cmp_q.en_lv, cmp_q.en_hv};
   assign cl        = {cmp_q.cur_limit_lv, cmp_q.cur_limit_hv};
   assign rail_low  = {cmp_q.rail_low_lv, cmp_q.rail_low_hv};
   assign ds_en     = {ctrl_q.discharge_gate_enable_lv,
                       ctrl_q.discharge_gate_enable_hv};
   assign bleed_en  = {ctrl_q.bleed_resistor_enable_lv,
                       ctrl_q.bleed_resistor_enable_hv};
   assign wr_status = reg_wr && (reg_addr == `HSFO_REG_STATUS);

   // Timer events per channel
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         wrap[i] = (cyc_q[i] == STEP_LAST);
         trip[i] = (st_q[i] == CH_ON) && en[i] && cl[i] &&
                   step_hit(stp_q[i], step_target(ft_q[i], 1'b0),
                            wrap[i]);
         retry_done[i] = step_hit(stp_q[i],
                                  step_target(ft_q[i], 1'b1),
                                  wrap[i]);
      end
   end

   // Configuration registers; a zero fault code is host misuse and
   // simply never trips, so it is stored as written
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_q <= hsfo_ctrl_t'(`HSFO_CTRL_RESET);
         ft_q[0] <= `HSFO_FT_RESET;
         ft_q[1] <= `HSFO_FT_RESET;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            `HSFO_REG_FT_HV: ft_q[0] <= reg_wdata[4:0];
            `HSFO_REG_FT_LV: ft_q[1] <= reg_wdata[4:0];
            `HSFO_REG_CTRL:
               ctrl_q <= hsfo_ctrl_t'(reg_wdata & `HSFO_CTRL_MASK);
            default: ;
         endcase
      end
   end

   // Sticky fault flags, write one to clear; a trip in the clearing
   // cycle wins so no fault is lost
   always_ff @(posedge clk)
   begin
      if (rst)
         flt_q <= 2'h0;
      else
      begin
         flt_q[0] <= trip[0] | (flt_q[0] &
                     ~(wr_status & reg_wdata[`HSFO_ST_FLT_HV]));
         flt_q[1] <= trip[1] | (flt_q[1] &
                     ~(wr_status & reg_wdata[`HSFO_ST_FLT_LV]));
      end
   end

   // Read data holds until the next read strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         rdata_q <= 8'h00;
      else if (reg_rd)
         rdata_q <= reg_read(reg_addr);
   end

   // Blocking gate with hysteresis; both thresholds cannot be crossed
   // at once, turn-on is checked first anyway
   always_ff @(posedge clk)
   begin
      if (rst || !ctrl_q.oring_driver_enable_hv)
         blk_q <= 1'b0;
      else if (cmp_q.diff_above_on)
         blk_q <= 1'b1;
      else if (ctrl_q.high_power_oring_select ? cmp_q.diff_below_pos
                                              : cmp_q.diff_below_neg)
         blk_q <= 1'b0;
   end

   // Bleed resistor switches follow the enable pins, not the state,
   // so a faulted but still enabled channel does not bleed its rail
   always_ff @(posedge clk)
   begin
      if (rst)
         bleed_q <= 2'h0;
      else
         bleed_q <= bleed_en & ~en;
   end

   // Channel state machines with fault and retry timers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < 2; i++)
         begin
            st_q[i]  <= CH_OFF;
            cyc_q[i] <= 16'h0000;
            stp_q[i] <= 12'h000;
         end
         pass_q <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            unique case (st_q[i])
               CH_OFF:
               begin
                  cyc_q[i] <= 16'h0000;
                  stp_q[i] <= 12'h000;
                  if (en[i] && ds_en[i] && !rail_low[i])
                  begin
                     st_q[i] <= CH_BLEED;
                  end
                  else if (en[i])
                  begin
                     st_q[i]   <= CH_ON;
                     pass_q[i] <= 1'b1;
                  end
               end
               CH_BLEED:
               begin
                  if (!en[i])
                  begin
                     st_q[i] <= CH_OFF;
                  end
                  else if (!ds_en[i] || rail_low[i])
                  begin
                     st_q[i]   <= CH_ON;
                     pass_q[i] <= 1'b1;
                  end
               end
               CH_ON:
               begin
                  if (!en[i])
                  begin
                     st_q[i]   <= CH_OFF;
                     pass_q[i] <= 1'b0;
                  end
                  else if (trip[i])
                  begin
                     st_q[i]   <= CH_FAULT;
                     pass_q[i] <= 1'b0;
                     cyc_q[i]  <= 16'h0000;
                     stp_q[i]  <= 12'h000;
                  end
                  else if (cl[i])
                  begin
                     // Count steps while limiting
                     cyc_q[i] <= wrap[i] ? 16'h0000
                                         : 16'(cyc_q[i] + 16'h0001);
                     if (wrap[i])
                     begin
                        stp_q[i] <= 12'(stp_q[i] + 12'h001);
                     end
                  end
                  else
                  begin
                     cyc_q[i] <= 16'h0000;
                     stp_q[i] <= 12'h000;
                  end
               end
               CH_FAULT:
               begin
                  if (!en[i])
                     st_q[i] <= CH_OFF;
                  else if (ctrl_q.fault_retry_select && retry_done[i])
                     st_q[i] <= CH_OFF;
                  else if (ctrl_q.fault_retry_select)
                  begin
                     cyc_q[i] <= wrap[i] ? 16'h0000
                                         : 16'(cyc_q[i] + 16'h0001);
                     if (wrap[i])
                     begin
                        stp_q[i] <= 12'(stp_q[i] + 12'h001);
                     end
                  end
                  else
                  begin
                     // Latched: wait for the enable pin to drop
                     cyc_q[i] <= 16'h0000;
                     stp_q[i] <= 12'h000;
                  end
               end
            endcase
         end
      end
   end

   // Outputs straight from flops
   assign reg_rdata           = rdata_q;
   assign blocking_gate_drive = blk_q;
   assign pass_gate_on        = pass_q;
   assign bleed_switch_on     = bleed_q;

endmodule : hsfo_ctrl

// ===== rtl/hsfo_params.svh
// Constants of the hot-swap fault and ORing control block.
// Assumes inclusion by the control module only.
`ifndef HSFO_PARAMS_SVH
`define HSFO_PARAMS_SVH

// Register numbers
`define HSFO_REG_FT_HV    8'h04
`define HSFO_REG_FT_LV    8'h05
`define HSFO_REG_CTRL     8'h10
`define HSFO_REG_STATUS   8'h11

// Reset values and control write mask
`define HSFO_FT_RESET     5'h01
`define HSFO_CTRL_RESET   8'h01
`define HSFO_CTRL_MASK    8'h7F

// Status bit positions
`define HSFO_ST_FLT_HV    0
`define HSFO_ST_FLT_LV    1
`define HSFO_ST_BLK       2
`define HSFO_ST_PASS_HV   3
`define HSFO_ST_PASS_LV   4
`define HSFO_ST_BLEED_HV  5
`define HSFO_ST_BLEED_LV  6

// Timing
`define HSFO_CLK_NS       100
`define HSFO_STEP_NS      450000
`define HSFO_RETRY_MULT   100

`endif

// ===== rtl/hsfo_pkg.sv
// Types shared by the hot-swap fault and ORing control block.
// Assumes the constants header sits beside it.
package hsfo_pkg;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic reserved;
      logic fault_retry_select;
      logic bleed_resistor_enable_lv;
      logic bleed_resistor_enable_hv;
      logic discharge_gate_enable_lv;
      logic discharge_gate_enable_hv;
      logic high_power_oring_select;
      logic oring_driver_enable_hv;
   } hsfo_ctrl_t;

   // Comparator and enable pin bundle
   typedef struct packed {
      logic en_lv;
      logic en_hv;
      logic rail_low_lv;
      logic rail_low_hv;
      logic cur_limit_lv;
      logic cur_limit_hv;
      logic diff_below_pos;
      logic diff_below_neg;
      logic diff_above_on;
   } hsfo_cmp_t;

   // Channel states
   typedef enum logic [1:0] {
      CH_OFF,
      CH_BLEED,
      CH_ON,
      CH_FAULT
   } hsfo_state_t;

endpackage : hsfo_pkg

// ===== test/hsfo_chk_sva.sv
// Checker of the hot-swap control block, seeing only its ports.
// Assumes registers change only through the byte port of the block.
`timescale 1ns/10ps
module hsfo_chk
   import hsfo_pkg::*;
#(
   parameter int STEP_CYCLES = 10
)(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Register port
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Pins and drives
   input wire hsfo_cmp_t  cmp_in,
   input wire logic       blocking_gate_drive,
   input wire logic [1:0] pass_gate_on,
   input wire logic [1:0] bleed_switch_on
);
   logic [7:0] ctrl_q;
   logic [4:0] ft_q;
   int         cnt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Shadow of control and 12 V fault time; 7 cycles cover pin sync
   always_ff @(posedge clk)
   begin
      if (rst)
         ctrl_q <= 8'h01;
      else if (reg_wr && reg_addr == 8'h10)
         ctrl_q <= reg_wdata & 8'h7F;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
         ft_q <= 5'h01;
      else if (reg_wr && reg_addr == 8'h04)
         ft_q <= reg_wdata[4:0];
   end
   // Cycles the 12 V pass has spent on inside current limit
   always_ff @(posedge clk)
   begin
      if (rst || !(pass_gate_on[0] && cmp_in.cur_limit_hv))
         cnt_q <= 0;
      else
         cnt_q <= cnt_q + 1;
   end
   sequence s_trip_hv;
      cmp_in.en_hv [*8] ##0 $fell(pass_gate_on[0]);
   endsequence
   a_gate_needs_en: assert property ((!ctrl_q[0]) [*2] |->
      !blocking_gate_drive) else $error("gate on while disabled");
   a_gate_turn_on: assert property ((ctrl_q[0] &&
      cmp_in.diff_above_on) [*7] |-> blocking_gate_drive)
      else $error("gate not on above threshold");
   a_gate_off_low: assert property ((!ctrl_q[1] &&
      cmp_in.diff_below_neg && !cmp_in.diff_above_on) [*7]
      |-> !blocking_gate_drive) else $error("gate not off low");
   a_gate_off_hp: assert property ((ctrl_q[1] &&
      cmp_in.diff_below_pos && !cmp_in.diff_above_on) [*7]
      |-> !blocking_gate_drive) else $error("gate not off in hp");
   a_bleed_closed: assert property ((ctrl_q[4] &&
      !cmp_in.en_hv) [*7] |-> bleed_switch_on[0])
      else $error("bleed switch open while disabled");
   a_pass_disabled: assert property ((!cmp_in.en_hv) [*7] |->
      !pass_gate_on[0]) else $error("pass on while disabled");
   a_trip_bound: assert property (ft_q != 5'h00 |->
      cnt_q <= int'(ft_q) * STEP_CYCLES + 6)
      else $error("fault timer overran");
   a_latch_off: assert property (s_trip_hv ##0 !ctrl_q[6] |=>
      (!pass_gate_on[0]) [*4]) else $error("latched channel restarted");
   a_read_ft: assert property (reg_rd && reg_addr == 8'h04 |=>
      reg_rdata == {3'h0, $past(ft_q)}) else $error("fault code misread");
endmodule : hsfo_chk

bind hsfo_ctrl hsfo_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.clk(clk),
   .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmp_in(cmp_in),
   .blocking_gate_drive(blocking_gate_drive),
   .pass_gate_on(pass_gate_on), .bleed_switch_on(bleed_switch_on));

// ===== test/hsfo_plant.sv
// Behavioural FETs and output rails beside the control block.
// Assumes the bench commands shorts; rails charge fast, sag slowly unless bled.
`timescale 1ns/10ps
module hsfo_plant (
   // Clock
   input  wire logic       clk,
   // Drives from the block
   input  wire logic [1:0] pass_gate_on,
   input  wire logic [1:0] bleed_switch_on,
   // Commanded output shorts
   input  wire logic [1:0] short_on,
   // Comparator levels back to the block
   output logic      [1:0] rail_low,
   output logic      [1:0] cur_limit
);
   int lvl_q [2] = '{0, 0};
   // Sag is slow without the bleed switch, so the hold-off is visible
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 2; i++)
         if (pass_gate_on[i] && !short_on[i])
            lvl_q[i] <= (lvl_q[i] > 90) ? 100 : lvl_q[i] + 10;
         else if (lvl_q[i] < 10)
            lvl_q[i] <= 0;
         else
            lvl_q[i] <= lvl_q[i] - (bleed_switch_on[i] ? 10 : 1);
   end
   // Rail low under a tenth of full; limit while feeding a short
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         rail_low[i] = lvl_q[i] < 10;
         cur_limit[i] = pass_gate_on[i] && short_on[i];
      end
   end
endmodule : hsfo_plant

// ===== test/testbench.sv
// Self-checking bench of the hot-swap control block.
// Assumes the plant model and the bound checker are compiled with it.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
   miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench
   import hsfo_pkg::*;
;
   localparam int STEP = 4;
   logic       clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_q = 0, g;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, m_e, m_m;
   logic [1:0] en = 2'h0, sh = 2'h0, rl, cl, pass, bleed;
   logic [2:0] dif = 3'h0;
   logic [2:0] dtab [4] = '{3'h1, 3'h0, 3'h4, 3'h6};
   logic [31:0] rs = 32'h0001_4E5D;
   logic       gate;
   hsfo_cmp_t  cmp;
   int         miscompares = 0, n_tests = 0, n;
   logic [7:0] eq [$], mq [$];
   string      nq [$], m_n;
   assign cmp = hsfo_cmp_t'({en, rl, cl, dif});
   always #50 clk = ~clk;
   hsfo_ctrl #(.STEP_CYCLES(STEP)) uut (.clk(clk), .rst(rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmp_in(cmp),
      .blocking_gate_drive(gate), .pass_gate_on(pass),
      .bleed_switch_on(bleed));
   hsfo_plant u_plant (.clk(clk), .pass_gate_on(pass),
      .bleed_switch_on(bleed), .short_on(sh), .rail_low(rl),
      .cur_limit(cl));
   // A read answers one edge later: take the oldest note then
   always @(posedge clk)
   begin
      if (rd_q)
      begin
         m_e = eq.pop_front();
         m_m = mq.pop_front();
         m_n = nq.pop_front();
         `CHK(m_n, m_e, reg_rdata & m_m)
      end
      rd_q <= reg_rd;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs
   // One register access; strobes stay up until the next access or cyc changes them
   task automatic acc(input logic w, input logic [7:0] a, d);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
   endtask : acc
   task automatic rd(input logic [7:0] a, e, m, input string s);
      eq.push_back(e & m);
      mq.push_back(m);
      nq.push_back(s);
      acc(0, a, 8'h00);
   endtask : rd
   task automatic cyc(input int c);
      reg_wr = 0;
      reg_rd = 0;
      repeat (c) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wpass(input int ch, input logic v, input int lim);
      n = 0;
      while (pass[ch] !== v && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK("pass wait", v, pass[ch])
   endtask : wpass
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // Watchdog sized well above the roughly two thousand cycles of the run
   initial
   begin
      repeat (6000) @(posedge clk);
      miscompares++;
      conclude();
   end
   initial
   begin
      cyc(10);
      rst = 0;
      // Reset values, unmapped read, dropped high code bits
      rd(8'h04, 8'h01, 8'hFF, "ft12");
      rd(8'h05, 8'h01, 8'hFF, "ft3v3");
      rd(8'h11, 8'h00, 8'hFF, "status");
      rd(8'h3C, 8'h00, 8'hFF, "unmapped");
      acc(1, 8'h04, 8'hE2);
      acc(1, 8'h05, 8'h03);
      rd(8'h04, 8'h02, 8'hFF, "ft12");
      g = 0;
      // Random differential class, ORing enable and threshold choice
      for (int i = 0; i < 40; i++)
      begin
         rs = xs(rs);
         acc(1, 8'h10, {6'h00, rs[4], rs[3:2] != 2'b00});
         // New control meets the settled old level first, then the new one
         for (int k = 0; k < 2; k++)
         begin
            if (k == 1)
               dif = dtab[rs[1:0]];
            if (rs[3:2] == 2'b00)
               g = 0;
            else if (dif[0])
               g = 1;
            else if (rs[4] ? dif[2] : dif[1])
               g = 0;
         end
         cyc(6);
         rd(8'h11, {5'h00, g, 2'h0}, 8'h04, "gate");
      end
      acc(1, 8'h10, 8'h31);
      cyc(9);
      rd(8'h11, 8'h60, 8'h60, "bleed on");
      // Bleed check: re-enable must wait for the rail to sag
      acc(1, 8'h10, 8'h05);
      en[0] = 1;
      cyc(20);
      en[0] = 0;
      cyc(8);
      rd(8'h11, 8'h00, 8'h28, "off no bleed");
      en[0] = 1;
      cyc(8);
      rd(8'h11, 8'h00, 8'h08, "held off");
      wpass(0, 1'b1, 150);
      `CHK("rail low", 1'b1, rl[0])
      // Shared rails: host keeps both bleed bits clear
      acc(1, 8'h10, 8'h01);
      cyc(20);
      // Latch mode trip, then W1C and re-enable
      sh[0] = 1;
      wpass(0, 1'b0, 40);
      `CHK("trip", 1'b1, n >= 2 * STEP && n <= 2 * STEP + 6)
      sh[0] = 0;
      cyc(30);
      rd(8'h11, 8'h01, 8'h09, "latched");
      acc(1, 8'h11, 8'h01);
      rd(8'h11, 8'h00, 8'h01, "flag clear");
      en[0] = 0;
      cyc(8);
      en[0] = 1;
      wpass(0, 1'b1, 20);
      // Limit pulses shorter than the fault time never trip
      for (int i = 0; i < 5; i++)
      begin
         sh[0] = 1;
         cyc(2 * STEP - 3);
         sh[0] = 0;
         cyc(6);
      end
      rd(8'h11, 8'h08, 8'h09, "no trip");
      // Retry mode on the low channel while the high one stays on
      acc(1, 8'h10, 8'h49);
      en[1] = 1;
      cyc(20);
      sh[1] = 1;
      wpass(1, 1'b0, 40);
      wpass(1, 1'b1, 1300);
      sh[1] = 0;
      `CHK("retry", 1'b1, n >= 300 * STEP - 1 && n <= 300 * STEP + 6)
      `CHK("other on", 1'b1, pass[0])
      cyc(40);
      rd(8'h11, 8'h1A, 8'h1A, "retried");
      acc(1, 8'h11, 8'h02);
      rd(8'h11, 8'h18, 8'h1B, "lv clear");
      cyc(2);
      conclude();
   end
endmodule : testbench
